// file: shared/i2csam_pkg.sv
// Package for the I2C slave address recognition block: map, fields, types
package i2csam_pkg;

    // Register byte offsets on the APB side
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_ADDR_FIRST = 8'h1c;
    localparam logic [7:0] OFF_ADDR_SECOND = 8'h20;
    localparam logic [7:0] OFF_ADDR_THIRD = 8'h24;
    localparam logic [7:0] OFF_MATCH = 8'h28;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h2c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h30;

    // Field positions
    localparam int ADDR_LSB = 1;
    localparam int ADDR_MSB = 7;
    localparam int GC_BIT = 0;
    localparam int CTRL_ACK_BIT = 2;
    localparam int CTRL_MASTER_BIT = 3;
    localparam int EV_MATCH_BIT = 0;
    localparam int EV_GCALL_BIT = 1;
    localparam int EV_STOP_BIT = 2;

    // Widths and reset values
    localparam int OWN_W = 7;
    localparam int EV_W = 3;
    localparam int BIT_CNT_W = 4;
    localparam logic [OWN_W-1:0] OWN_RESET = 7'h00;
    localparam logic [OWN_W-1:0] GCALL_ADDR = 7'h00;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;
    localparam logic [BIT_CNT_W-1:0] LAST_ADDR_BIT = 4'h7;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_WAIT,
        ST_ACK,
        ST_DONE,
        ST_IGNORE
    } i2csam_fsm_t;

    // Software-visible configuration
    typedef struct packed {
        logic [OWN_W-1:0] own_address_zero;
        logic general_call_enable;
        logic [OWN_W-1:0] own_address_one;
        logic [OWN_W-1:0] own_address_two;
        logic ack_control;
        logic master_mode;
        logic [EV_W-1:0] irq_mask;
    } i2csam_cfg_t;

    // Two-flop synchronisers plus one history stage per line
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } i2csam_sync_t;

    // Whole state of the block
    typedef struct packed {
        i2csam_cfg_t cfg;
        i2csam_sync_t scl;
        i2csam_sync_t sda;
        i2csam_fsm_t fsm;
        logic [7:0] shift;
        logic [BIT_CNT_W-1:0] bit_cnt;
        logic [EV_W-1:0] match;
        logic [EV_W-1:0] irq_stat;
        logic sda_drive;
        logic addressed;
        logic read_dir;
        logic [31:0] prdata;
    } i2csam_state_t;

endpackage

// file: hdl/i2csam_top.sv
// I2C slave address recognition with APB registers and match interrupt
//
// Added by the designer: the APB interface to the registers.

module i2csam_top (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // I2C bus, open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Status towards the rest of the controller
    output logic slave_addressed,
    output logic slave_read,
    output logic irq
);

    i2csam_pkg::i2csam_state_t st_reg;
    i2csam_pkg::i2csam_state_t st_next;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] byte_now;
    logic [i2csam_pkg::OWN_W-1:0] dev_addr;
    logic [i2csam_pkg::EV_W-1:0] own_hit;
    logic gc_hit;
    logic any_hit;
    logic [i2csam_pkg::EV_W-1:0] ev;
    logic [i2csam_pkg::EV_W-1:0] w1c;
    logic apb_setup;
    logic apb_write;
    logic mapped;
    logic [31:0] rd_word;

    // Flow of one addressing phase:
    //   START seen on the synchronised lines, match flags and counter cleared
    //   Eight SCL rises shift the address byte in, MSB first
    //   On the eighth rise the decision is made; outside master mode the match flags load
    //   If taken, SDA is pulled low from the next SCL fall to the one after
    //   The block is then addressed until the next START or STOP
    // Limitation: SCL and SDA pass two flops, so the pins must hold each
    // level for at least three pclk periods or an edge is missed.
    // Trade-off: the match decision uses the byte as it stands after the
    // last shift, which saves a cycle but makes the compare combinational.
    // Hazard: a glitch on SDA while SCL is high reads as START or STOP;
    // there is no spike filter in front of the synchronisers.

    // Edges are taken from the synchronised stage against its history,
    // never from the metastable first flop
    always_comb begin
        scl_rise = st_reg.scl.sync & ~st_reg.scl.prev;
        scl_fall = ~st_reg.scl.sync & st_reg.scl.prev;
        bus_start = st_reg.scl.sync & st_reg.scl.prev &
                    st_reg.sda.prev & ~st_reg.sda.sync;
        bus_stop = st_reg.scl.sync & st_reg.scl.prev &
                   ~st_reg.sda.prev & st_reg.sda.sync;
    end

    // Address byte as it stands after the current bit is shifted in
    always_comb begin
        byte_now = {st_reg.shift[6:0], st_reg.sda.sync};
        dev_addr = byte_now[i2csam_pkg::ADDR_MSB:i2csam_pkg::ADDR_LSB];
    end

    // A zero own address is reserved, so it never matches a broadcast
    always_comb begin
        own_hit[0] = (st_reg.cfg.own_address_zero != i2csam_pkg::OWN_RESET)
                     && (dev_addr == st_reg.cfg.own_address_zero);
        own_hit[1] = (st_reg.cfg.own_address_one != i2csam_pkg::OWN_RESET)
                     && (dev_addr == st_reg.cfg.own_address_one);
        own_hit[2] = (st_reg.cfg.own_address_two != i2csam_pkg::OWN_RESET)
                     && (dev_addr == st_reg.cfg.own_address_two);
        gc_hit = st_reg.cfg.general_call_enable &&
                 (dev_addr == i2csam_pkg::GCALL_ADDR);
        any_hit = (|own_hit) | gc_hit;
    end

    // APB decode
    always_comb begin
        apb_setup = psel & ~penable;
        apb_write = psel & penable & pwrite & ce;
        case (paddr)
            i2csam_pkg::OFF_CTRL,
            i2csam_pkg::OFF_ADDR_FIRST,
            i2csam_pkg::OFF_ADDR_SECOND,
            i2csam_pkg::OFF_ADDR_THIRD,
            i2csam_pkg::OFF_MATCH,
            i2csam_pkg::OFF_IRQ_STAT,
            i2csam_pkg::OFF_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read word, captured into a flop during the setup cycle
    always_comb begin
        rd_word = i2csam_pkg::READ_ZERO;
        case (paddr)
            i2csam_pkg::OFF_CTRL: begin
                rd_word[i2csam_pkg::CTRL_ACK_BIT] = st_reg.cfg.ack_control;
                rd_word[i2csam_pkg::CTRL_MASTER_BIT] = st_reg.cfg.master_mode;
            end
            i2csam_pkg::OFF_ADDR_FIRST: begin
                rd_word[i2csam_pkg::ADDR_MSB:i2csam_pkg::ADDR_LSB] =
                    st_reg.cfg.own_address_zero;
                rd_word[i2csam_pkg::GC_BIT] = st_reg.cfg.general_call_enable;
            end
            i2csam_pkg::OFF_ADDR_SECOND: begin
                rd_word[i2csam_pkg::ADDR_MSB:i2csam_pkg::ADDR_LSB] =
                    st_reg.cfg.own_address_one;
            end
            i2csam_pkg::OFF_ADDR_THIRD: begin
                rd_word[i2csam_pkg::ADDR_MSB:i2csam_pkg::ADDR_LSB] =
                    st_reg.cfg.own_address_two;
            end
            i2csam_pkg::OFF_MATCH: begin
                rd_word[i2csam_pkg::EV_W-1:0] = st_reg.match;
            end
            i2csam_pkg::OFF_IRQ_STAT: begin
                rd_word[i2csam_pkg::EV_W-1:0] = st_reg.irq_stat;
            end
            i2csam_pkg::OFF_IRQ_MASK: begin
                rd_word[i2csam_pkg::EV_W-1:0] = st_reg.cfg.irq_mask;
            end
            default: rd_word = i2csam_pkg::READ_ZERO;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        ev = i2csam_pkg::EV_RESET;
        w1c = i2csam_pkg::EV_RESET;

        // Two-flop synchronisers with one history stage
        st_next.scl.meta = scl_i;
        st_next.scl.sync = st_reg.scl.meta;
        st_next.scl.prev = st_reg.scl.sync;
        st_next.sda.meta = sda_i;
        st_next.sda.sync = st_reg.sda.meta;
        st_next.sda.prev = st_reg.sda.sync;

        // Bus side
        // START and STOP take priority over any bit in flight, so a frame
        // cut short by the master never leaves SDA pulled low.
        // A repeated START is handled exactly as a first START.
        if (bus_start) begin
            st_next.match = i2csam_pkg::EV_RESET;
            st_next.fsm = i2csam_pkg::ST_ADDR;
            st_next.bit_cnt = '0;
            st_next.sda_drive = 1'b0;
            st_next.addressed = 1'b0;
        end else if (bus_stop) begin
            st_next.match = i2csam_pkg::EV_RESET;
            st_next.fsm = i2csam_pkg::ST_IDLE;
            st_next.sda_drive = 1'b0;
            st_next.addressed = 1'b0;
            ev[i2csam_pkg::EV_STOP_BIT] = 1'b1;
        end else begin
            case (st_reg.fsm)
                i2csam_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        st_next.shift = byte_now;
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                        if (st_reg.bit_cnt == i2csam_pkg::LAST_ADDR_BIT) begin
                            // Own addresses count for nothing as master
                            if (st_reg.cfg.master_mode) begin
                                st_next.fsm = i2csam_pkg::ST_IGNORE;
                            end else begin
                                st_next.match = own_hit;
                                if (any_hit && st_reg.cfg.ack_control) begin
                                    st_next.fsm = i2csam_pkg::ST_ACK_WAIT;
                                    st_next.read_dir = byte_now[0];
                                    ev[i2csam_pkg::EV_MATCH_BIT] =
                                        |own_hit;
                                    ev[i2csam_pkg::EV_GCALL_BIT] =
                                        gc_hit;
                                end else begin
                                    // No drive on SDA: master sees NACK
                                    st_next.fsm =
                                        i2csam_pkg::ST_IGNORE;
                                end
                            end
                        end
                    end
                end
                i2csam_pkg::ST_ACK_WAIT: begin
                    if (scl_fall) begin
                        st_next.sda_drive = 1'b1;
                        st_next.fsm = i2csam_pkg::ST_ACK;
                    end
                end
                i2csam_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        st_next.sda_drive = 1'b0;
                        st_next.addressed = 1'b1;
                        st_next.fsm = i2csam_pkg::ST_DONE;
                    end
                end
                i2csam_pkg::ST_IDLE,
                i2csam_pkg::ST_DONE,
                i2csam_pkg::ST_IGNORE: begin
                    st_next.fsm = st_reg.fsm;
                end
                default: begin
                    st_next.fsm = i2csam_pkg::ST_IDLE;
                    st_next.sda_drive = 1'b0;
                end
            endcase
        end

        // APB side
        // Read data is captured in the setup cycle so that prdata comes
        // straight from a flop; a flag that changes during the access
        // phase shows up on the next read.
        if (apb_setup) begin
            st_next.prdata = rd_word;
        end
        // Writes to the match flags or to unmapped offsets change nothing
        if (apb_write) begin
            case (paddr)
                i2csam_pkg::OFF_CTRL: begin
                    st_next.cfg.ack_control =
                        pwdata[i2csam_pkg::CTRL_ACK_BIT];
                    st_next.cfg.master_mode =
                        pwdata[i2csam_pkg::CTRL_MASTER_BIT];
                end
                i2csam_pkg::OFF_ADDR_FIRST: begin
                    st_next.cfg.own_address_zero =
                        pwdata[i2csam_pkg::ADDR_MSB:i2csam_pkg::ADDR_LSB];
                    st_next.cfg.general_call_enable =
                        pwdata[i2csam_pkg::GC_BIT];
                end
                i2csam_pkg::OFF_ADDR_SECOND: begin
                    st_next.cfg.own_address_one =
                        pwdata[i2csam_pkg::ADDR_MSB:i2csam_pkg::ADDR_LSB];
                end
                i2csam_pkg::OFF_ADDR_THIRD: begin
                    st_next.cfg.own_address_two =
                        pwdata[i2csam_pkg::ADDR_MSB:i2csam_pkg::ADDR_LSB];
                end
                i2csam_pkg::OFF_IRQ_STAT: begin
                    w1c = pwdata[i2csam_pkg::EV_W-1:0];
                end
                i2csam_pkg::OFF_IRQ_MASK: begin
                    st_next.cfg.irq_mask = pwdata[i2csam_pkg::EV_W-1:0];
                end
                default: begin
                    st_next.cfg = st_reg.cfg;
                end
            endcase
        end

        // A new event in the clearing cycle survives the clear
        st_next.irq_stat = (st_reg.irq_stat & ~w1c) | ev;
    end

    // Reset clears configuration, flags and bus state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.scl <= 3'h7;
            st_reg.sda <= 3'h7;
            st_reg.fsm <= i2csam_pkg::ST_IDLE;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Zero wait state; a low clock enable stretches the access phase
    always_comb begin
        pready = ce;
        pslverr = psel & penable & ~mapped;
        prdata = st_reg.prdata;
        sda_o = 1'b0;
        sda_oe = st_reg.sda_drive;
        slave_addressed = st_reg.addressed;
        slave_read = st_reg.read_dir;
        irq = |(st_reg.irq_stat & st_reg.cfg.irq_mask);
    end

endmodule

// file: bench/i2csam_props.sv
// Checker for address recognition and register read rules at the top ports
module i2csam_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // I2C and status
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic slave_addressed,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] scl_reg, sda_reg;
    logic ack_reg, mst_reg, acc, bus_cond;
    logic [4:0] oe_cnt_reg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign acc = psel && penable && pready && !pwrite;
    // SDA moving while SCL is high: START or STOP
    assign bus_cond = scl_reg[1] && (sda_reg[1] != sda_reg[2]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_reg <= 3'h7;
            sda_reg <= 3'h7;
            ack_reg <= 1'b0;
            mst_reg <= 1'b0;
            oe_cnt_reg <= 5'h00;
        end else begin
            scl_reg <= {scl_reg[1:0], scl_i};
            sda_reg <= {sda_reg[1:0], sda_i};
            oe_cnt_reg <= sda_oe ? oe_cnt_reg + 5'h01 : 5'h00;
            if (psel && penable && pready && pwrite &&
                paddr == i2csam_pkg::OFF_CTRL) begin
                ack_reg <= pwdata[i2csam_pkg::CTRL_ACK_BIT];
                mst_reg <= pwdata[i2csam_pkg::CTRL_MASTER_BIT];
            end
        end
    end
    a_oe_open_drain: assert property (sda_oe |-> !sda_o)
        else $error("sda driven high");
    a_oe_needs_ack: assert property (sda_oe |-> ack_reg && !mst_reg)
        else $error("ack driven without ack control");
    a_oe_one_bit: assert property (oe_cnt_reg <= 5'h10)
        else $error("ack drive too long");
    a_ack_then_addr: assert property ($fell(sda_oe) |-> ##[0:2] slave_addressed)
        else $error("ack given but not addressed");
    a_clear_bus_cond: assert property (bus_cond |-> ##[0:4] !slave_addressed)
        else $error("addressed kept over start or stop");
    a_master_no_addr: assert property (mst_reg |-> !$rose(slave_addressed))
        else $error("addressed in master mode");
    a_match_upper_zero: assert property (acc && paddr ==
        i2csam_pkg::OFF_MATCH |-> prdata[31:3] == 29'h0)
        else $error("match upper bits set");
    a_addr_rsvd_zero: assert property (acc && (paddr ==
        i2csam_pkg::OFF_ADDR_SECOND || paddr == i2csam_pkg::OFF_ADDR_THIRD)
        |-> prdata[31:8] == 24'h0 && !prdata[0])
        else $error("reserved address bits set");
    cover property ($rose(slave_addressed));
    cover property ($rose(irq));
    cover property (bus_cond && sda_reg[1]);
endmodule

// file: bench/i2csam_mst.sv
// Behavioural I2C bus master driving SCL and its share of SDA
module i2csam_mst (
    // Bus lines; SCL stands high outside frames, SDA pulled up
    output logic scl,
    output logic sda_m,
    input wire logic sda_w
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Also a repeated START when SCL is low
    task automatic start();
        sda_m = 1'b1;
        #16 scl = 1'b1;
        #16 sda_m = 1'b0;
        #16 scl = 1'b0;
        #16;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        #16 scl = 1'b1;
        #16 sda_m = 1'b1;
        #32;
    endtask
    // Byte MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_m = b[i];
            #16 scl = 1'b1;
            #32 scl = 1'b0;
            #16;
        end
        sda_m = 1'b1;
        #16 scl = 1'b1;
        #16 ack = !sda_w;
        #16 scl = 1'b0;
        #32;
    endtask
endmodule

// file: bench/i2csam_top_tb.sv
// Top testbench: register access and I2C address matching vs a model
module i2csam_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic sda_o, sda_oe, slave_addressed, slave_read, irq;
    logic scl, sda_m, sda_w, ackb, rw, slv;
    int error_cnt, n_compared, cyc, a, hits, ea, stat;
    int own[3];
    int q[$];
    // Per mode: ack control, general call, master, irq mask
    int md[4][4] = '{'{1, 1, 0, 7}, '{0, 1, 0, 0}, '{1, 0, 0, 2},
        '{1, 1, 1, 1}};
    assign sda_w = (sda_oe && !sda_o) ? 1'b0 : sda_m;
    i2csam_mst mst (.scl, .sda_m, .sda_w);
    i2csam_top dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i(scl),
        .sda_i(sda_w), .sda_o, .sda_oe, .slave_addressed, .slave_read,
        .irq);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Whole run needs a few thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 12000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        seed = 32'h2a7805e4;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, i2csam_pkg::OFF_ADDR_SECOND + 8'(4 * i), '0);
            chk("reset value", rd, '0);
            apb(1'b1, i2csam_pkg::OFF_ADDR_SECOND + 8'(4 * i), '1);
            apb(1'b0, i2csam_pkg::OFF_ADDR_SECOND + 8'(4 * i), '0);
            chk("write back", rd, 32'(i < 2 ? 8'hfe : 8'h00));
        end
        apb(1'b0, 8'hfc, '0);
        chk("unmapped read", rd, '0);
        chk("unmapped error", 32'(slv), 32'h1);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            own[i] = {seed[6:1], 1'b1};
            apb(1'b1, i2csam_pkg::OFF_ADDR_FIRST + 8'(4 * i), 32'(own[i] << 1));
        end
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, i2csam_pkg::OFF_ADDR_FIRST, 32'(own[0] << 1 | md[m][1]));
            apb(1'b1, i2csam_pkg::OFF_CTRL, 32'(md[m][0] << 2 | md[m][2] << 3));
            apb(1'b1, i2csam_pkg::OFF_IRQ_MASK, 32'(md[m][3]));
            seed = lfsr(seed);
            q = {own[0], own[1], own[2], 0, int'(seed[6:0])};
            foreach (q[k]) begin
                a = q[k];
                rw = seed[k + 8] && a != 0;
                mst.start();
                apb(1'b0, i2csam_pkg::OFF_MATCH, '0);
                chk("match after start", rd, '0);
                mst.xfer({a[6:0], rw}, ackb);
                hits = 0;
                for (int i = 0; i < 3; i++)
                    if (a == own[i] && !md[m][2]) hits |= 1 << i;
                ea = md[m][0] && !md[m][2] && (hits != 0 || (a == 0 && md[m][1]));
                apb(1'b0, i2csam_pkg::OFF_MATCH, '0);
                chk("match flags", rd, 32'(hits));
                chk("ack", 32'(ackb), 32'(ea));
                chk("addressed", 32'(slave_addressed), 32'(ea));
                if (ea) chk("direction", 32'(slave_read), 32'(rw));
                stat = ea ? (a == 0 ? 2 : 1) : 0;
                apb(1'b0, i2csam_pkg::OFF_IRQ_STAT, '0);
                chk("event", rd, 32'(stat));
                chk("irq", 32'(irq), 32'((stat & md[m][3]) != 0));
                apb(1'b1, i2csam_pkg::OFF_IRQ_STAT, 32'(stat));
            end
            mst.stop();
            apb(1'b0, i2csam_pkg::OFF_MATCH, '0);
            chk("match after stop", rd, '0);
            chk("addressed after stop", 32'(slave_addressed), '0);
            apb(1'b1, i2csam_pkg::OFF_IRQ_STAT, 32'h7);
        end
        end_sim();
    end
endmodule
bind i2csam_top i2csam_props u_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .pready, .paddr, .pwdata, .prdata, .scl_i, .sda_i, .sda_o,
    .sda_oe, .slave_addressed, .irq);
